/* src/tcp_timer.sv */
// 16-bit timer with capture, square-wave and programmable pulse output
//
// Contract
// RULE1 - free-running: valid edge on input a captures counter into cap one, irq one
// RULE2 - software selects both edges on input a for single-register measurement
// RULE3 - captures need the new level on two successive count clock samples
// RULE4 - free-running: edge on input b captures into cap zero, sets irq zero; the code ignores input b in two-register mode
// RULE5 - two-register mode: opposite edge on input a captures into cap zero
// RULE6 - software clears the overflow flag; hardware never clears it
// RULE7 - restart mode: edge captures into cap one then counter restarts at zero
// RULE8 - software selects rising or falling edge in restart mode
// RULE9 - with both edges selected on input a, cap zero never captures; the code still lets input b capture into it in single-register mode
// RULE10 - square wave: output toggles every compare zero plus one count clocks
// RULE11 - software loads compare zero nonzero for square wave
// RULE12 - software configures square wave registers in order, mode last
// RULE13 - software avoids rewriting compare zero while counting
// RULE14 - pulse mode drives period from compare zero, width from compare one
// RULE15 - pulse mode clears the counter on match with compare zero
// RULE16 - software keeps compare one below compare zero, zero not allowed
// RULE17 - period is compare zero plus one, active width compare one plus one
// RULE18 - software configures pulse mode registers in order, mode last
// RULE19 - overflow flag sets when counter wraps from maximum to zero
// RULE20 - capture registers hold their value until the next capture
`timescale 1ns/1ps
module tcp_timer #(
    parameter int CNT_W = tcp_pkg::CNT_W
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire tcp_pkg::tcp_mode_e  timer_mode_ctrl_reg,
    input  wire logic [7:0]          prescaler_mode_reg,
    input  wire tcp_pkg::tcp_capsel_e capcmp_ctrl_reg,
    input  wire logic [1:0]          output_ctrl_reg,
    input  wire logic [CNT_W-1:0]    cmp_zero_wr_data,
    input  wire logic                cmp_zero_wr,
    input  wire logic [CNT_W-1:0]    cmp_one_wr_data,
    input  wire logic                cmp_one_wr,
    input  wire logic                overflow_clr,
    input  wire logic                timer_input_a,
    input  wire logic                timer_input_b,
    output logic [CNT_W-1:0]         up_counter,
    output logic [CNT_W-1:0]         cap_cmp_zero,
    output logic [CNT_W-1:0]         cap_cmp_one,
    output logic                     overflow_flag,
    output logic                     irq_match_zero,
    output logic                     irq_match_one,
    output logic                     timer_output_pin
);
    // elaboration check: the logic serves only the documented counter width
    if (CNT_W != tcp_pkg::CNT_W)
    begin : g_bad_cnt_w
        $error("tcp_timer supports only a 16-bit counter");
    end

    // ****************************************
    // prescaler tick
    // ****************************************
    logic [2:0] pre_reg, pre_next;
    logic       tick;
    logic [2:0] pre_top;

    always_comb
    begin
        case (prescaler_mode_reg[tcp_pkg::PRS_SEL_HI_BIT:tcp_pkg::PRS_SEL_LO_BIT])
            2'h0:    pre_top = 3'(tcp_pkg::PRS_DIV1 - 1);
            2'h1:    pre_top = 3'(tcp_pkg::PRS_DIV2 - 1);
            2'h2:    pre_top = 3'(tcp_pkg::PRS_DIV4 - 1);
            default: pre_top = 3'(tcp_pkg::PRS_DIV8 - 1);
        endcase
        tick     = (pre_reg >= pre_top);
        pre_next = tick ? 3'h0 : pre_reg + 3'h1;
    end

    // ****************************************
    // filtered edges
    // ****************************************
    tcp_edge_if ev_a ();
    tcp_edge_if ev_b ();

    tcp_edge_det u_det_a (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick),
        .pin     (timer_input_a),
        .ev      (ev_a.src)
    );

    tcp_edge_det u_det_b (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick),
        .pin     (timer_input_b),
        .ev      (ev_b.src)
    );

    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        case (sel)
            tcp_pkg::ES_FALL: edge_hit = f;
            tcp_pkg::ES_RISE: edge_hit = r;
            tcp_pkg::ES_BOTH: edge_hit = r | f;
            default:          edge_hit = 1'b0;
        endcase
    endfunction

    logic [1:0] es_a;
    logic [1:0] es_b;
    logic       hit_a, inv_a, hit_b;
    assign es_a  = prescaler_mode_reg[tcp_pkg::ES_A_HI_BIT:tcp_pkg::ES_A_LO_BIT];
    assign es_b  = prescaler_mode_reg[tcp_pkg::ES_B_HI_BIT:tcp_pkg::ES_B_LO_BIT];
    assign hit_a = edge_hit(es_a, ev_a.rise, ev_a.fall);
    assign inv_a = (es_a != tcp_pkg::ES_BOTH) && edge_hit(es_a, ev_a.fall, ev_a.rise);
    assign hit_b = edge_hit(es_b, ev_b.rise, ev_b.fall);

    // ****************************************
    // counter, captures, output
    // ****************************************
    logic [CNT_W-1:0] cnt_next, c0_next, c1_next;
    logic             ovf_next, irq0_next, irq1_next, out_next;
    logic             running, free_cap, two_reg, match0, match1;

    always_comb
    begin
        running   = (timer_mode_ctrl_reg != tcp_pkg::TCP_STOP);
        free_cap  = (timer_mode_ctrl_reg == tcp_pkg::TCP_FREE);
        two_reg   = (capcmp_ctrl_reg == tcp_pkg::TCP_CAP_TWO);
        match0    = (up_counter == cap_cmp_zero);
        match1    = (up_counter == cap_cmp_one);
        cnt_next  = up_counter;
        c0_next   = cmp_zero_wr ? cmp_zero_wr_data : cap_cmp_zero;
        c1_next   = cmp_one_wr ? cmp_one_wr_data : cap_cmp_one;
        ovf_next  = overflow_flag & ~overflow_clr; // [RULE6]
        irq0_next = 1'b0;
        irq1_next = 1'b0;
        out_next  = timer_output_pin;
        if (!running)
            cnt_next = tcp_pkg::CNT_RST;
        else
        begin
            if (tick)
            begin
                cnt_next = up_counter + tcp_pkg::CNT_ONE;
                if (up_counter == tcp_pkg::CNT_MAX)
                    ovf_next = 1'b1; // [RULE19]
                if ((timer_mode_ctrl_reg == tcp_pkg::TCP_MATCH ||
                     timer_mode_ctrl_reg == tcp_pkg::TCP_PPG) && match0)
                begin
                    cnt_next  = tcp_pkg::CNT_RST; // [RULE15]
                    irq0_next = 1'b1;
                    if (output_ctrl_reg[tcp_pkg::OUT_EN_BIT] &&
                        timer_mode_ctrl_reg == tcp_pkg::TCP_MATCH &&
                        output_ctrl_reg[tcp_pkg::TOG_M0_BIT])
                        out_next = ~timer_output_pin; // [RULE10]
                end
                if (timer_mode_ctrl_reg == tcp_pkg::TCP_PPG &&
                    output_ctrl_reg[tcp_pkg::OUT_EN_BIT])
                begin
                    // high from zero through compare one [RULE14] [RULE17]
                    if (match0)
                        out_next = 1'b1;
                    else if (match1)
                        out_next = 1'b0;
                    if (match1)
                        irq1_next = 1'b1;
                end
            end
            if (free_cap && hit_a)
            begin
                c1_next   = up_counter; // [RULE1]
                irq1_next = 1'b1;
            end
            if (free_cap && two_reg && inv_a)
                c0_next = up_counter; // [RULE5] [RULE9]
            else if (free_cap && !two_reg && hit_b)
            begin
                c0_next   = up_counter; // [RULE4]
                irq0_next = 1'b1;
            end
            if (timer_mode_ctrl_reg == tcp_pkg::TCP_RESTART && hit_a)
            begin
                c1_next   = up_counter; // [RULE7]
                irq1_next = 1'b1;
                cnt_next  = tcp_pkg::CNT_RST;
            end
        end
        if (!output_ctrl_reg[tcp_pkg::OUT_EN_BIT])
            out_next = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pre_reg          <= 3'h0;
            up_counter       <= tcp_pkg::CNT_RST;
            cap_cmp_zero     <= tcp_pkg::CNT_RST;
            cap_cmp_one      <= tcp_pkg::CNT_RST;
            overflow_flag    <= 1'b0;
            irq_match_zero   <= 1'b0;
            irq_match_one    <= 1'b0;
            timer_output_pin <= 1'b0;
        end
        else
        begin
            pre_reg          <= pre_next;
            up_counter       <= cnt_next;
            cap_cmp_zero     <= c0_next; // [RULE20]
            cap_cmp_one      <= c1_next;
            overflow_flag    <= ovf_next;
            irq_match_zero   <= irq0_next;
            irq_match_one    <= irq1_next;
            timer_output_pin <= out_next;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_cap_a;
        free_cap && hit_a && running && !cmp_one_wr;
    endsequence

    AST_CAP_ONE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
        s_cap_a |=> cap_cmp_one == $past(up_counter) && irq_match_one)
        else $error("capture one missed");
    AST_CAP_ZERO_B: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
        free_cap && !two_reg && hit_b && !cmp_zero_wr
        |=> cap_cmp_zero == $past(up_counter) && irq_match_zero)
        else $error("capture zero on input b missed");
    AST_CAP_ZERO_INV: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
        free_cap && two_reg && inv_a && !cmp_zero_wr
        |=> cap_cmp_zero == $past(up_counter))
        else $error("inverse edge capture missed");
    AST_NO_CAP_BOTH: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
        two_reg && es_a == tcp_pkg::ES_BOTH && !cmp_zero_wr && !(free_cap && hit_b && !two_reg)
        |=> $stable(cap_cmp_zero))
        else $error("cap zero changed with both edges");
    AST_RESTART: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
        timer_mode_ctrl_reg == tcp_pkg::TCP_RESTART && hit_a
        |=> up_counter == tcp_pkg::CNT_RST && irq_match_one)
        else $error("restart did not clear counter");
    AST_OVF_SET: assert property (@(posedge clk) disable iff (sys_rst) // [RULE19]
        running && tick && up_counter == tcp_pkg::CNT_MAX |=> overflow_flag)
        else $error("overflow not flagged");
    AST_OVF_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
        overflow_flag && !overflow_clr |=> overflow_flag)
        else $error("overflow cleared by hardware");
    AST_PPG_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
        timer_mode_ctrl_reg == tcp_pkg::TCP_PPG && tick && match0
        |=> up_counter == tcp_pkg::CNT_RST)
        else $error("pulse mode did not clear on match");
    AST_SQ_TOGGLE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
        timer_mode_ctrl_reg == tcp_pkg::TCP_MATCH && output_ctrl_reg == 2'h3 && tick && match0
        |=> timer_output_pin != $past(timer_output_pin))
        else $error("square wave did not toggle");
    AST_PPG_LEVEL: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14] [RULE17]
        timer_mode_ctrl_reg == tcp_pkg::TCP_PPG && output_ctrl_reg[0] && tick && match1 && !match0
        |=> !timer_output_pin)
        else $error("pulse did not end at compare one");
endmodule // tcp_timer

/* src/tcp_pkg.sv */
// package of constants and types for the timer capture and pulse output block
package tcp_pkg;

    // ****************************************
    // widths and register field positions
    // ****************************************
    localparam int CNT_W          = 16;
    localparam int ES_A_LO_BIT    = 4;
    localparam int ES_A_HI_BIT    = 5;
    localparam int ES_B_LO_BIT    = 6;
    localparam int ES_B_HI_BIT    = 7;
    localparam int PRS_SEL_LO_BIT = 0;
    localparam int PRS_SEL_HI_BIT = 1;
    localparam int OUT_EN_BIT     = 0;
    localparam int TOG_M0_BIT     = 1;

    // ****************************************
    // edge select codes, counter constants and prescaler divides
    // ****************************************
    localparam logic [1:0]  ES_FALL    = 2'h0;
    localparam logic [1:0]  ES_RISE    = 2'h1;
    localparam logic [1:0]  ES_BOTH    = 2'h3;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam int          PRS_DIV1   = 1;
    localparam int          PRS_DIV2   = 2;
    localparam int          PRS_DIV4   = 4;
    localparam int          PRS_DIV8   = 8;

    // ****************************************
    // operating modes
    // ****************************************
    typedef enum logic [4:0] {
        TCP_STOP    = 5'h01,
        TCP_FREE    = 5'h02,
        TCP_RESTART = 5'h04,
        TCP_MATCH   = 5'h08,
        TCP_PPG     = 5'h10
    } tcp_mode_e;

    // capture control: two register capture in TCP_CAP_TWO
    typedef enum logic [1:0] {
        TCP_CAP_ONE = 2'h1,
        TCP_CAP_TWO = 2'h2
    } tcp_capsel_e;

endpackage

/* src/tcp_edge_if.sv */
// interface carrying filtered edge events from the edge detector
`timescale 1ns/1ps
interface tcp_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

/* src/tcp_edge_det.sv */
// input filter and edge detector sampled on the count clock tick
`timescale 1ns/1ps
module tcp_edge_det (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic tick,
    input  wire logic pin,
    tcp_edge_if.src   ev
);
    logic s1_reg, s1_next;
    logic s2_reg, s2_next;
    logic lvl_reg, lvl_next;
    logic rise_next, fall_next;

    // ****************************************
    // two sample qualification
    // ****************************************
    always_comb
    begin
        s1_next   = s1_reg;
        s2_next   = s2_reg;
        lvl_next  = lvl_reg;
        rise_next = 1'b0;
        fall_next = 1'b0;
        if (tick)
        begin
            s1_next = pin;
            s2_next = s1_reg;
            // new level must be seen on two successive samples [RULE3]
            if (s1_reg == s2_reg && s2_reg != lvl_reg)
            begin
                lvl_next  = s2_reg;
                rise_next = s2_reg;
                fall_next = ~s2_reg;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            lvl_reg <= 1'b0;
            ev.rise <= 1'b0;
            ev.fall <= 1'b0;
        end
        else
        begin
            s1_reg  <= s1_next;
            s2_reg  <= s2_next;
            lvl_reg <= lvl_next;
            ev.rise <= rise_next;
            ev.fall <= fall_next;
        end
    end

    AST_FILTER_TWO: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
        ev.rise |-> $past(s1_reg) && $past(s2_reg))
        else $error("rise without two high samples");
endmodule // tcp_edge_det

/* bench/tcp_pulse_src.sv */
// partner model: pulse sources on the timer inputs and watcher of the output pin
`timescale 1ns/1ps
module tcp_pulse_src (
    input  wire logic clk,
    input  wire logic out_pin,
    output logic      pin_a,
    output logic      pin_b
);
    initial
    begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // new level set at a falling edge, then held for hold clocks
    task automatic drive(input logic sel_b, input logic lvl, input int hold);
        if (sel_b)
            pin_b = lvl;
        else
            pin_a = lvl;
        repeat (hold) @(negedge clk);
    endtask

    // clocks spent at one level, bounded
    task automatic span(input logic lvl, output int cnt);
        cnt = 0;
        while (out_pin === lvl && cnt < 300)
        begin
            @(negedge clk);
            cnt++;
        end
    endtask

    // high time and period of the output pin from a rising edge
    task automatic measure(output int hi, output int per);
        int lo;
        span(1'b1, lo);
        span(1'b0, lo);
        span(1'b1, hi);
        span(1'b0, lo);
        per = hi + lo;
    endtask
endmodule // tcp_pulse_src

/* bench/test_timer_capture_pulse_output.sv */
// self-checking testbench of the timer capture and pulse output block
`timescale 1ns/1ps
module test_timer_capture_pulse_output;
    logic               clk;
    logic               sys_rst;
    tcp_pkg::tcp_mode_e  mode;
    logic [7:0]         prm;
    tcp_pkg::tcp_capsel_e capsel;
    logic [1:0]         outc;
    logic [15:0]        cz_d;
    logic [15:0]        co_d;
    logic               cz_wr;
    logic               co_wr;
    logic               ovf_clr;
    logic               pin_a;
    logic               pin_b;
    logic [15:0]        up_counter;
    logic [15:0]        cap_cmp_zero;
    logic [15:0]        cap_cmp_one;
    logic               overflow_flag;
    logic               irq_match_zero;
    logic               irq_match_one;
    logic               timer_output_pin;
    logic [15:0]        q0[$];
    logic [15:0]        q1[$];
    int                 hi;
    int                 per;
    int                 n;
    int                 mismatches = 0;
    int                 tests_run = 0;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    tcp_timer tcp_timer_i (
        .clk(clk), .sys_rst(sys_rst), .timer_mode_ctrl_reg(mode),
        .prescaler_mode_reg(prm), .capcmp_ctrl_reg(capsel), .output_ctrl_reg(outc),
        .cmp_zero_wr_data(cz_d), .cmp_zero_wr(cz_wr), .cmp_one_wr_data(co_d),
        .cmp_one_wr(co_wr), .overflow_clr(ovf_clr), .timer_input_a(pin_a),
        .timer_input_b(pin_b), .up_counter(up_counter), .cap_cmp_zero(cap_cmp_zero),
        .cap_cmp_one(cap_cmp_one), .overflow_flag(overflow_flag),
        .irq_match_zero(irq_match_zero), .irq_match_one(irq_match_one),
        .timer_output_pin(timer_output_pin)
    );

    tcp_pulse_src tcp_pulse_src_i (
        .clk(clk), .out_pin(timer_output_pin), .pin_a(pin_a), .pin_b(pin_b)
    );

    // ****************************************
    // capture log, one entry per request pulse
    // ****************************************
    always @(negedge clk)
    begin
        if (irq_match_one === 1'b1)
            q1.push_back(cap_cmp_one);
        if (irq_match_zero === 1'b1)
            q0.push_back(cap_cmp_zero);
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic setup(input tcp_pkg::tcp_mode_e m, input logic [7:0] p,
                         input tcp_pkg::tcp_capsel_e c, input logic [1:0] o,
                         input logic [15:0] cz, input logic [15:0] co);
        mode = tcp_pkg::TCP_STOP;
        @(negedge clk);
        // compare values are written only while the counter is stopped
        prm = p;
        capsel = c;
        outc = o;
        cz_d = cz;
        co_d = co;
        cz_wr = 1'b1;
        co_wr = 1'b1;
        @(negedge clk);
        cz_wr = 1'b0;
        co_wr = 1'b0;
        mode = m;
        @(negedge clk);
        q0.delete();
        q1.delete();
    endtask

    task automatic end_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, mismatches);
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        mode = tcp_pkg::TCP_STOP;
        prm = 8'h00;
        capsel = tcp_pkg::TCP_CAP_ONE;
        outc = 2'h0;
        cz_d = 16'h0000;
        co_d = 16'h0000;
        cz_wr = 1'b0;
        co_wr = 1'b0;
        ovf_clr = 1'b0;
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        setup(tcp_pkg::TCP_FREE, 8'h30, tcp_pkg::TCP_CAP_ONE, 2'h0, 16'h0000, 16'h0000);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 40);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 40);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 30);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 1);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 20);
        check("captures on input a", 16'h0003, 16'(q1.size()));
        check("high width", 16'h0028, q1[1] - q1[0]);
        check("low width", 16'h0028, q1[2] - q1[1]);
        check("cap one held", q1[2], cap_cmp_one);
        check("no zero capture", 16'h0000, 16'(q0.size()));
        tcp_pulse_src_i.drive(1'b0, 1'b0, 20);
        end_test("one register capture");
        setup(tcp_pkg::TCP_FREE, 8'hF0, tcp_pkg::TCP_CAP_ONE, 2'h0, 16'h0000, 16'h0000);
        tcp_pulse_src_i.drive(1'b1, 1'b1, 25);
        tcp_pulse_src_i.drive(1'b1, 1'b0, 25);
        check("captures on input b", 16'h0002, 16'(q0.size()));
        check("b width", 16'h0019, q0[1] - q0[0]);
        setup(tcp_pkg::TCP_FREE, 8'hF2, tcp_pkg::TCP_CAP_ONE, 2'h0, 16'h0000, 16'h0000);
        tcp_pulse_src_i.drive(1'b1, 1'b1, 48);
        tcp_pulse_src_i.drive(1'b1, 1'b0, 40);
        check("b width in ticks", 16'h000C, q0[1] - q0[0]);
        end_test("input b capture");
        setup(tcp_pkg::TCP_FREE, 8'h10, tcp_pkg::TCP_CAP_TWO, 2'h0, 16'h0000, 16'h0000);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 30);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 20);
        check("rise captures", 16'h0001, 16'(q1.size()));
        check("two register width", 16'h001E, cap_cmp_zero - q1[0]);
        setup(tcp_pkg::TCP_FREE, 8'h30, tcp_pkg::TCP_CAP_TWO, 2'h0, 16'h0000, 16'h0000);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 20);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 20);
        check("both edge captures", 16'h0002, 16'(q1.size()));
        check("cap zero untouched", 16'h0000, cap_cmp_zero);
        end_test("two register capture");
        setup(tcp_pkg::TCP_RESTART, 8'h10, tcp_pkg::TCP_CAP_ONE, 2'h0, 16'h0000, 16'h0000);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 10);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 40);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 10);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 20);
        check("restart captures", 16'h0002, 16'(q1.size()));
        check("restart period", 16'h0031, q1[1]);
        check("counter cleared", 16'h0000, {6'h00, up_counter[15:6]});
        setup(tcp_pkg::TCP_RESTART, 8'h03, tcp_pkg::TCP_CAP_ONE, 2'h0, 16'h0000, 16'h0000);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 40);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 40);
        tcp_pulse_src_i.drive(1'b0, 1'b1, 40);
        tcp_pulse_src_i.drive(1'b0, 1'b0, 40);
        check("falling restart captures", 16'h0002, 16'(q1.size()));
        check("falling restart ticks", 16'h000A, q1[1]);
        end_test("restart measurement");
        setup(tcp_pkg::TCP_MATCH, 8'h00, tcp_pkg::TCP_CAP_ONE, 2'h3, 16'h0009, 16'h0000);
        tcp_pulse_src_i.measure(hi, per);
        check("square half period", 16'h000A, 16'(hi));
        check("square period", 16'h0014, 16'(per));
        setup(tcp_pkg::TCP_MATCH, 8'h01, tcp_pkg::TCP_CAP_ONE, 2'h3, 16'h0009, 16'h0000);
        tcp_pulse_src_i.measure(hi, per);
        check("square half period div2", 16'h0014, 16'(hi));
        check("square period div2", 16'h0028, 16'(per));
        end_test("square wave");
        setup(tcp_pkg::TCP_PPG, 8'h00, tcp_pkg::TCP_CAP_ONE, 2'h3, 16'h0013, 16'h0004);
        tcp_pulse_src_i.measure(hi, per);
        check("pulse width", 16'h0005, 16'(hi));
        check("pulse period", 16'h0014, 16'(per));
        setup(tcp_pkg::TCP_PPG, 8'h00, tcp_pkg::TCP_CAP_ONE, 2'h0, 16'h0013, 16'h0004);
        repeat (30) @(negedge clk);
        check("pin with output off", 16'h0000, {15'h0000, timer_output_pin});
        end_test("programmable pulse");
        setup(tcp_pkg::TCP_FREE, 8'h00, tcp_pkg::TCP_CAP_ONE, 2'h0, 16'h0000, 16'h0000);
        n = 0;
        while (overflow_flag !== 1'b1 && n < 70000)
        begin
            @(negedge clk);
            n++;
        end
        check("overflow flag", 16'h0001, {15'h0000, overflow_flag});
        check("counter after wrap", 16'h0000, {4'h0, up_counter[15:4]});
        repeat (20) @(negedge clk);
        check("flag stays set", 16'h0001, {15'h0000, overflow_flag});
        ovf_clr = 1'b1;
        @(negedge clk);
        ovf_clr = 1'b0;
        @(negedge clk);
        check("flag cleared", 16'h0000, {15'h0000, overflow_flag});
        end_test("overflow");
        close_out();
    end
endmodule // test_timer_capture_pulse_output
